// >>> src/pmicio_pins.sv
/*
  Pin logic of the three configurable I/O pins: relay pin, reset output pin,
  core reset pin, with register port and core rail voltage registers.
  Assumes pin inputs synchronous-ish to clk (still double-registered), a
  sequencer that may pull the open-drain pins low, and a supplies-good level
  from the power monitor on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RULE_01] With relay select clear the relay pin is open drain: low for 0, released for 1.
// [RULE_02] With relay select set and supplies good the output pin copies the relay pin.
// [RULE_03] On loss of supplies good the output pin holds the level caught at that edge.
// [RULE_04] After reset and before supplies good first rises the relayed output is low.
// [RULE_05] With relay select clear and push-pull clear the output pin is open drain on its bit.
// [RULE_06] With relay select clear and push-pull set the output pin is push-pull on its bit.
// [RULE_07] In relay mode the output user bit is ignored but push-pull still picks the drive.
// [RULE_08] With core reset enable clear the core pin is open drain on its bit or the sequencer.
// [RULE_09] With core reset enable set the core pin is an input and its user bit is ignored.
// [RULE_10] A falling edge on the core pin in that mode restores only the two core rail codes.
// [RULE_11] Software sets relay select to use the relay; the output pin then drives by itself.
// [RULE_12] Both pin inputs pass two flip-flops before any use.
module pmicio_pins #(
  parameter logic [5:0] RAIL_A_DEFAULT = pmicio_pkg::RAIL_A_DEF,
  parameter logic [5:0] RAIL_B_DEFAULT = pmicio_pkg::RAIL_B_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [3:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [15:0] reg_rdata,
  input  wire logic       main_supplies_good,
  input  wire logic       seq_relay_low,
  input  wire logic       seq_core_low,
  input  wire logic       reset_relay_pin_i,
  output var  logic       reset_relay_pin_o,
  output var  logic       reset_relay_pin_oe,
  output var  logic       reset_out_pin_o,
  output var  logic       reset_out_pin_oe,
  input  wire logic       core_reset_pin_i,
  output var  logic       core_reset_pin_o,
  output var  logic       core_reset_pin_oe,
  output var  logic [5:0] core_buck_a_code,
  output var  logic [5:0] core_buck_b_code
);

  // ----------------------------------------------------------------
  // Configuration and user registers
  // ----------------------------------------------------------------
  logic [2:0] cfg_r;
  logic [2:0] user_r;
  logic [5:0] rail_a_r;
  logic [5:0] rail_b_r;
  logic       relay_sel;
  logic       push_pull;
  logic       core_rst_en;
  assign relay_sel   = cfg_r[pmicio_pkg::CFG_RELAY_SEL];
  assign push_pull   = cfg_r[pmicio_pkg::CFG_PUSH_PULL];
  assign core_rst_en = cfg_r[pmicio_pkg::CFG_CORE_RST];

  // Address decode
  logic wr_cfg;
  logic wr_user;
  logic wr_rails;
  assign wr_cfg   = reg_wr && (reg_addr == pmicio_pkg::ADDR_CFG);
  assign wr_user  = reg_wr && (reg_addr == pmicio_pkg::ADDR_USER);
  assign wr_rails = reg_wr && (reg_addr == pmicio_pkg::ADDR_RAILS);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // [RULE_12] two-stage synchronisers
  logic [1:0] relay_sync_r;
  logic [1:0] core_sync_r;
  logic       core_prev_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      relay_sync_r <= 2'h3;
      core_sync_r  <= 2'h3;
      core_prev_r  <= 1'b1;
    end else if (ce) begin
      relay_sync_r <= {relay_sync_r[0], reset_relay_pin_i};
      core_sync_r  <= {core_sync_r[0], core_reset_pin_i};
      core_prev_r  <= core_sync_r[1];
    end
  end
  logic relay_lvl;
  logic core_lvl;
  logic core_fall;
  assign relay_lvl = relay_sync_r[1];
  assign core_lvl  = core_sync_r[1];
  // [RULE_10] edge only counts while the pin is an input
  assign core_fall = core_rst_en && core_prev_r && !core_lvl;

  // ----------------------------------------------------------------
  // Relay latch
  // ----------------------------------------------------------------
  // Supplies good is taken as already on the clock domain.
  logic sup_seen_r;
  logic relay_q_r;
  logic relay_q_nxt;
  // [RULE_02] follow while good; [RULE_03] freeze while not good
  // [RULE_04] low until supplies good has been seen once
  assign relay_q_nxt = !sup_seen_r && !main_supplies_good ? 1'b0 :
                       main_supplies_good ? relay_lvl : relay_q_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      sup_seen_r <= 1'b0;
      relay_q_r  <= 1'b0;
    end else if (ce) begin
      sup_seen_r <= sup_seen_r | main_supplies_good;
      relay_q_r  <= relay_q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic out_lvl;
  logic out_oe_nxt;
  logic relay_oe_nxt;
  logic core_oe_nxt;
  // [RULE_07] relay mode ignores the user bit; [RULE_11] output set automatically
  assign out_lvl = relay_sel ? relay_q_nxt : user_r[pmicio_pkg::USR_OUT_LVL];
  // [RULE_05] open drain drives only low; [RULE_06] push-pull always drives
  assign out_oe_nxt = push_pull | !out_lvl;
  // [RULE_01] open drain relay pin, released in relay mode
  assign relay_oe_nxt = !relay_sel &&
                        (!user_r[pmicio_pkg::USR_RELAY_LVL] || seq_relay_low);
  // [RULE_08] open drain core pin; [RULE_09] input when reset enabled
  assign core_oe_nxt = !core_rst_en &&
                       (!user_r[pmicio_pkg::USR_CORE_LVL] || seq_core_low);

  // Registered pin outputs; open-drain data stays 0
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_relay_pin_o  <= 1'b0;
      reset_relay_pin_oe <= 1'b0;
      reset_out_pin_o    <= 1'b0;
      reset_out_pin_oe   <= 1'b0;
      core_reset_pin_o   <= 1'b0;
      core_reset_pin_oe  <= 1'b0;
    end else if (ce) begin
      reset_relay_pin_o  <= 1'b0;
      reset_relay_pin_oe <= relay_oe_nxt;
      reset_out_pin_o    <= push_pull & out_lvl;
      reset_out_pin_oe   <= out_oe_nxt;
      core_reset_pin_o   <= 1'b0;
      core_reset_pin_oe  <= core_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Pin reset edge wins over a same-cycle software write to the rails.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r    <= pmicio_pkg::CFG_RESET;
      user_r   <= pmicio_pkg::USER_RESET;
      rail_a_r <= RAIL_A_DEFAULT;
      rail_b_r <= RAIL_B_DEFAULT;
    end else if (ce) begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata[2:0];
      end
      if (wr_user) begin
        user_r <= reg_wdata[2:0];
      end
      // [RULE_10] only the two rail codes go back to default
      if (core_fall) begin
        rail_a_r <= RAIL_A_DEFAULT;
        rail_b_r <= RAIL_B_DEFAULT;
      end else if (wr_rails) begin
        rail_a_r <= reg_wdata[pmicio_pkg::RAIL_W-1:0];
        rail_b_r <= reg_wdata[pmicio_pkg::RAIL_B_LSB +: pmicio_pkg::RAIL_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [4:0]  status;
  assign status = {!sup_seen_r ? 1'b0 : !main_supplies_good, sup_seen_r,
                   relay_q_r, core_lvl, relay_lvl};
  assign rd_mux = (reg_addr == pmicio_pkg::ADDR_CFG)    ? {13'h0000, cfg_r} :
                  (reg_addr == pmicio_pkg::ADDR_USER)   ? {13'h0000, user_r} :
                  (reg_addr == pmicio_pkg::ADDR_STATUS) ? {11'h000, status} :
                  (reg_addr == pmicio_pkg::ADDR_RAILS)  ?
                    {2'h0, rail_b_r, 2'h0, rail_a_r} : 16'h0000;
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata        <= 16'h0000;
      core_buck_a_code <= RAIL_A_DEFAULT;
      core_buck_b_code <= RAIL_B_DEFAULT;
    end else if (ce) begin
      reg_rdata        <= reg_rd ? rd_mux : 16'h0000;
      core_buck_a_code <= rail_a_r;
      core_buck_b_code <= rail_b_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_relay_od_drive: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
    ce && !relay_sel && !user_r[0] |=> reset_relay_pin_oe && !reset_relay_pin_o)
    else $error("relay pin not driven low");
  a_relay_follow: assert property (@(posedge clk) disable iff (rst) // [RULE_02]
    ce && relay_sel && main_supplies_good && push_pull |=> reset_out_pin_o == $past(relay_lvl))
    else $error("output pin does not follow relay pin");
  a_relay_hold: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
    ce && sup_seen_r && !main_supplies_good |=> relay_q_r == $past(relay_q_r))
    else $error("relay latch changed while supplies bad");
  a_relay_por_low: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
    !sup_seen_r |-> relay_q_r == 1'b0)
    else $error("relay output high before first supplies good");
  a_out_od: assert property (@(posedge clk) disable iff (rst) // [RULE_05]
    ce && !relay_sel && !push_pull && user_r[1] |=> !reset_out_pin_oe)
    else $error("open drain output not released");
  a_out_pp: assert property (@(posedge clk) disable iff (rst) // [RULE_06]
    ce && !relay_sel && push_pull |=> reset_out_pin_oe && reset_out_pin_o == $past(user_r[1]))
    else $error("push-pull output wrong");
  a_core_input: assert property (@(posedge clk) disable iff (rst) // [RULE_09]
    ce && core_rst_en |=> !core_reset_pin_oe)
    else $error("core pin driven in input mode");
  a_core_rail_rst: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
    ce && core_fall |=> rail_a_r == RAIL_A_DEFAULT && rail_b_r == RAIL_B_DEFAULT)
    else $error("rail codes not restored");
  a_core_od: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
    ce && !core_rst_en && seq_core_low |=> core_reset_pin_oe)
    else $error("core pin not pulled by sequencer");
  c_relay_latch: cover property (@(posedge clk) relay_sel && $fell(main_supplies_good));
  c_core_reset:  cover property (@(posedge clk) core_fall);
  c_push_pull:   cover property (@(posedge clk) push_pull && reset_out_pin_o);

endmodule : pmicio_pins
`default_nettype wire

// >>> src/pmicio_pkg.sv
/*
  Package for the pin configuration block of the power management device.
  Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
package pmicio_pkg;
  // ----------------------------------------------------------------
  // Register map (plain register port, word-wide index addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CFG    = 4'h0;  // Pin mode configuration
  localparam logic [3:0] ADDR_USER   = 4'h1;  // User level bits
  localparam logic [3:0] ADDR_STATUS = 4'h2;  // Pin and relay status, read only
  localparam logic [3:0] ADDR_RAILS  = 4'h3;  // Core buck voltage codes
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_RELAY_SEL  = 0;
  localparam int CFG_PUSH_PULL  = 1;
  localparam int CFG_CORE_RST   = 2;
  localparam int USR_RELAY_LVL  = 0;
  localparam int USR_OUT_LVL    = 1;
  localparam int USR_CORE_LVL   = 2;
  localparam int ST_RELAY_PIN   = 0;
  localparam int ST_CORE_PIN    = 1;
  localparam int ST_OUT_LEVEL   = 2;
  localparam int ST_SUP_SEEN    = 3;
  localparam int ST_HELD        = 4;
  localparam int RAIL_W         = 6;
  localparam int RAIL_B_LSB     = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_RESET  = 3'h0;
  localparam logic [2:0] USER_RESET = 3'h7;     // All pins released
  localparam logic [5:0] RAIL_A_DEF = 6'h08;    // Plain default code
  localparam logic [5:0] RAIL_B_DEF = 6'h08;    // Plain default code
endpackage : pmicio_pkg

// >>> verif/pmicio_host.sv
/*
  Host processor model: drives the memory reset level and the core reset request.
  Assumes pull-ups on both open-drain pins of the device.
*/
`timescale 1ns/1ps
`default_nettype none
module pmicio_host (
  input  wire logic relay_oe,
  input  wire logic core_oe,
  input  wire logic mem_rst_en,
  input  wire logic mem_rst_lvl,
  input  wire logic core_rst_low,
  output var  logic relay_wire,
  output var  logic core_wire
);
  // ----------------------------------------------------------------
  // Wire levels
  // ----------------------------------------------------------------
  // host drives relay pin
  always_comb relay_wire = relay_oe ? 1'b0 : (mem_rst_en ? mem_rst_lvl : 1'b1);
  // host pulls core pin low, pull-up otherwise
  always_comb core_wire = (core_oe || core_rst_low) ? 1'b0 : 1'b1;
endmodule : pmicio_host
`default_nettype wire

// >>> verif/pmic_io_pin_config_tb_top.sv
/*
  Self-checking bench for the pin configuration block.
  Assumes a host model on the relay and core pins and pull-ups on both.
*/
`timescale 1ns/1ps
`default_nettype none
module pmic_io_pin_config_tb_top;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, sup = 0, sq_r = 0, sq_c = 0;
  logic men = 0, mlvl = 0, clow = 0, rw, cw, rp_o, rp_oe, op_o, op_oe, cp_o, cp_oe;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, r;
  logic [5:0]  ca, cb;
  logic        l, sr, sc;
  logic [2:0]  uv;
  int          miscompares = 0, check_count = 0, cyc = 0;
  localparam logic [15:0] RDEF = {2'b0, pmicio_pkg::RAIL_B_DEF, 2'b0, pmicio_pkg::RAIL_A_DEF};
  pmicio_pins pmicio_pins_inst (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .main_supplies_good(sup), .seq_relay_low(sq_r), .seq_core_low(sq_c),
    .reset_relay_pin_i(rw), .reset_relay_pin_o(rp_o), .reset_relay_pin_oe(rp_oe),
    .reset_out_pin_o(op_o), .reset_out_pin_oe(op_oe), .core_reset_pin_i(cw),
    .core_reset_pin_o(cp_o), .core_reset_pin_oe(cp_oe), .core_buck_a_code(ca),
    .core_buck_b_code(cb));
  pmicio_host pmicio_host_inst (.relay_oe(rp_oe), .core_oe(cp_oe), .mem_rst_en(men),
    .mem_rst_lvl(mlvl), .core_rst_low(clow), .relay_wire(rw), .core_wire(cw));
  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task automatic rreg(logic [3:0] a, logic [15:0] e, string n);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(n, e, rdata);
  endtask : rreg
  task automatic waitn(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitn
  // Pin summary: relay oe, out oe, out level, core oe
  function automatic logic [15:0] pins();
    return {12'h0, rp_oe, op_oe, op_o, cp_oe};
  endfunction : pins
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h470b));
    repeat (10) @(posedge clk);
    rst <= 0;
    rreg(pmicio_pkg::ADDR_CFG, 16'h0000, "cfg_reset");
    rreg(pmicio_pkg::ADDR_USER, 16'h0007, "user_reset");
    rreg(pmicio_pkg::ADDR_RAILS, RDEF, "rails_reset");
    rreg(4'h9, 16'h0000, "unmapped");
    // Every drive mode and user level, sequencer pulls at random
    for (int p = 0; p < 2; p++) begin
      for (int u = 0; u < 8; u++) begin
        sr = 1'($urandom);
        sc = 1'($urandom);
        @(posedge clk);
        sq_r <= sr;
        sq_c <= sc;
        wreg(pmicio_pkg::ADDR_CFG, 16'(p << 1));
        wreg(pmicio_pkg::ADDR_USER, 16'(u));
        waitn(3);
        chk("od_pins", {12'h0, !u[0] | sr, p[0] | !u[1], p[0] & u[1], !u[2] | sc},
            pins());
        chk("od_data", 16'h0000, {14'h0, rp_o, cp_o});
      end
    end
    @(posedge clk);
    sq_r <= 0;
    sq_c <= 0;
    men <= 1;
    mlvl <= 1;
    wreg(pmicio_pkg::ADDR_CFG, 16'h0003);
    waitn(6);
    chk("relay_pre_good", 16'h0004, pins());
    @(posedge clk);
    sup <= 1;
    // Relayed level follows the host while supplies are good
    for (int i = 0; i < 6; i++) begin
      l = 1'($urandom);
      uv = 3'($urandom);
      @(posedge clk);
      mlvl <= l;
      wreg(pmicio_pkg::ADDR_USER, 16'(uv));
      waitn(6);
      chk("relay_follow", {12'h0, 2'b01, l, !uv[2]}, pins());
    end
    @(posedge clk);
    sup <= 0;
    repeat (3) @(posedge clk);
    mlvl <= !l;
    waitn(6);
    chk("relay_hold", {12'h0, 2'b01, l, !uv[2]}, pins());
    rreg(pmicio_pkg::ADDR_STATUS, {11'h0, 2'b11, l, uv[2], !l}, "status");
    wreg(pmicio_pkg::ADDR_CFG, 16'h0001);
    waitn(3);
    chk("relay_od", {12'h0, 1'b0, !l, 1'b0, !uv[2]}, pins());
    // Core rail restore on a falling core pin
    r = 16'($urandom) & 16'h3F3F;
    // A written code equal to the default would hide a missing restore
    if (r == RDEF) r = 16'h0101;
    wreg(pmicio_pkg::ADDR_RAILS, r);
    waitn(2);
    chk("codes", r, {2'b0, cb, 2'b0, ca});
    wreg(pmicio_pkg::ADDR_CFG, 16'h0004);
    wreg(pmicio_pkg::ADDR_USER, 16'h0000);
    waitn(3);
    chk("core_input", 16'h0000, {15'h0, cp_oe});
    @(posedge clk);
    clow <= 1;
    waitn(8);
    chk("codes_restored", RDEF, {2'b0, cb, 2'b0, ca});
    rreg(pmicio_pkg::ADDR_RAILS, RDEF, "rails_restored");
    rreg(pmicio_pkg::ADDR_CFG, 16'h0004, "cfg_kept");
    rreg(pmicio_pkg::ADDR_USER, 16'h0000, "user_kept");
    // Clock enable low must swallow a write
    @(posedge clk);
    ce <= 0;
    wreg(pmicio_pkg::ADDR_USER, 16'h0007);
    @(posedge clk);
    ce <= 1;
    rreg(pmicio_pkg::ADDR_USER, 16'h0000, "ce_frozen");
    end_sim();
  end
endmodule : pmic_io_pin_config_tb_top
`default_nettype wire
